// ==== hdl/misc_cfg_pkg.sv ====
// Package: offsets, field layouts, reset values and carrier types of the misc configuration bank
package misc_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_Q_FULLSCALE_LOW   = 8'h1a;
  localparam logic [7:0] OFS_Q_FULLSCALE_HIGH  = 8'h1b;
  localparam logic [7:0] OFS_TEMP_SENSOR_CTRL  = 8'h1c;
  localparam logic [7:0] OFS_TEMPERATURE_LOW   = 8'h1d;
  localparam logic [7:0] OFS_TEMPERATURE_HIGH  = 8'h1e;
  localparam logic [7:0] OFS_PART_IDENTIFIER   = 8'h1f;
  localparam logic [7:0] OFS_IRQ_CONFIGURATION = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_Q_FULLSCALE_LOW   = 8'hf9;
  localparam logic [1:0] RST_Q_FULLSCALE_HIGH  = 2'h1;
  localparam logic [2:0] RST_SPAN_CURRENT      = 3'h0;
  localparam logic [2:0] RST_REF_CURRENT       = 3'h1;
  localparam logic       RST_SENSOR_ENABLE     = 1'b0;
  localparam logic [7:0] RST_TEMPERATURE_BYTE  = 8'h00;
  localparam logic [7:0] RST_IRQ_MODE_SELECT   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FS_HIGH_MSB     = 1;
  localparam int SPAN_CUR_MSB    = 6;
  localparam int SPAN_CUR_LSB    = 4;
  localparam int REF_CUR_MSB     = 3;
  localparam int REF_CUR_LSB     = 1;
  localparam int SENSOR_EN_BIT   = 0;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_MODE_TEST        = 8'h00;
  localparam logic [7:0] IRQ_MODE_RECOMMENDED = 8'h01;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] span_current;
    logic [2:0] ref_current;
    logic       enable;
  } sensor_ctrl_t;

endpackage

// ==== hdl/dac_misc_config_registers.sv ====
// Design: byte-wide configuration and status register bank of the converter
//
// Function
// - Quadrature full-scale code is ten bits: low byte at 0x1a, bits 1:0 at 0x1b.
// - After reset the full-scale code equals 0x1f9, which means 20 mA.
// - Sensor bits 6:4 pick ADC span current; reset value is zero.
// - Sensor bits 3:1 pick ADC reference current; reset value is one.
// - Sensor bit 0 enables the temperature sensor; cleared by reset.
// - Die temperature is sixteen read-only bits at 0x1d and 0x1e, zero after reset.
// - Identification register at 0x1f returns a fixed code; writes ignored.
// - Irq_mode_select resets to 0x00 test mode; software writes 0x01.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps

module dac_misc_config_registers #(
  parameter logic [7:0] PART_ID_VALUE = 8'h5c  // Arbitrary neutral value
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire misc_cfg_pkg::reg_req_t     reg_req,
  output logic [7:0]                      rd_data,
  input  wire logic                       temp_valid,
  input  wire logic [15:0]                temp_value,
  output logic [9:0]                      q_fullscale_code,
  output misc_cfg_pkg::sensor_ctrl_t      sensor_ctrl,
  output logic [7:0]                      irq_mode_select,
  output logic                            irq_test_mode
);
  import misc_cfg_pkg::*;

  logic [7:0]   fs_low_q;
  logic [1:0]   fs_high_q;
  sensor_ctrl_t sens_q;
  logic [15:0]  temp_q;
  logic [7:0]   irq_cfg_q;
  logic [7:0]   rd_data_d;
  logic [7:0]   rd_data_q;

  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The span and reference current struct members are three bits wide; a field layout of another width
  // would silently truncate writes, so refuse it here.
  if ((SPAN_CUR_MSB - SPAN_CUR_LSB) != 2 || (REF_CUR_MSB - REF_CUR_LSB) != 2) begin : g_bad_field
    $error("sensor current fields must be three bits wide");
  end
  if (FS_HIGH_MSB != 1) begin : g_bad_fs_high
    $error("full-scale high part must be two bits wide");
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fs_low_q  <= RST_Q_FULLSCALE_LOW;
      fs_high_q <= RST_Q_FULLSCALE_HIGH;
    end else begin
      if (wr_hit(reg_req, OFS_Q_FULLSCALE_LOW)) begin
        fs_low_q <= reg_req.wdata;
      end
      if (wr_hit(reg_req, OFS_Q_FULLSCALE_HIGH)) begin
        fs_high_q <= reg_req.wdata[FS_HIGH_MSB:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sens_q.span_current <= RST_SPAN_CURRENT;
      sens_q.ref_current  <= RST_REF_CURRENT;
      sens_q.enable       <= RST_SENSOR_ENABLE;
    end else if (wr_hit(reg_req, OFS_TEMP_SENSOR_CTRL)) begin
      sens_q.span_current <= reg_req.wdata[SPAN_CUR_MSB:SPAN_CUR_LSB];
      sens_q.ref_current  <= reg_req.wdata[REF_CUR_MSB:REF_CUR_LSB];
      sens_q.enable       <= reg_req.wdata[SENSOR_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_cfg_q <= RST_IRQ_MODE_SELECT;
    end else if (wr_hit(reg_req, OFS_IRQ_CONFIGURATION)) begin
      irq_cfg_q <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Temperature readback
  // ----------------------------------------------------------------
  // Both bytes update together so a low/high read pair from one sample is coherent
  // unless a new result lands between the two reads.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= {RST_TEMPERATURE_BYTE, RST_TEMPERATURE_BYTE};
    end else if (temp_valid && sens_q.enable) begin
      temp_q <= temp_value;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_d = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_Q_FULLSCALE_LOW:   rd_data_d = fs_low_q;
        OFS_Q_FULLSCALE_HIGH:  rd_data_d = {6'h00, fs_high_q};
        OFS_TEMP_SENSOR_CTRL:  rd_data_d = {1'b0, sens_q.span_current,
                                            sens_q.ref_current, sens_q.enable};
        OFS_TEMPERATURE_LOW:   rd_data_d = temp_q[7:0];
        OFS_TEMPERATURE_HIGH:  rd_data_d = temp_q[15:8];
        OFS_PART_IDENTIFIER:   rd_data_d = PART_ID_VALUE;
        OFS_IRQ_CONFIGURATION: rd_data_d = irq_cfg_q;
        default:               rd_data_d = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data          = rd_data_q;
  assign q_fullscale_code = {fs_high_q, fs_low_q};
  assign sensor_ctrl      = sens_q;
  assign irq_mode_select  = irq_cfg_q;
  assign irq_test_mode    = (irq_cfg_q == IRQ_MODE_TEST);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_rd(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence

  // A sample is taken only while the sensor is enabled
  sequence s_temp_take;
    temp_valid && sens_q.enable;
  endsequence

  sequence s_temp_quiet;
    !(temp_valid && sens_q.enable);
  endsequence

  chk_fs_code_join: assert property (
    wr_hit(reg_req, OFS_Q_FULLSCALE_HIGH) |=> q_fullscale_code[9:8] == $past(reg_req.wdata[1:0]))
    else $error("full-scale high bits not taken from write");

  chk_fs_low_join: assert property (
    wr_hit(reg_req, OFS_Q_FULLSCALE_LOW) |=> q_fullscale_code[7:0] == $past(reg_req.wdata))
    else $error("full-scale low byte not taken from write");

  chk_fs_reset_value: assert property (
    $rose(rst_b) |-> q_fullscale_code == 10'h1f9)
    else $error("full-scale code not 0x1f9 after reset");

  chk_span_field: assert property (
    wr_hit(reg_req, OFS_TEMP_SENSOR_CTRL) |=> sensor_ctrl.span_current == $past(reg_req.wdata[6:4]))
    else $error("span current field wrong");

  chk_ref_field: assert property (
    wr_hit(reg_req, OFS_TEMP_SENSOR_CTRL) |=> sensor_ctrl.ref_current == $past(reg_req.wdata[3:1]))
    else $error("reference current field wrong");

  chk_sensor_enable: assert property (
    wr_hit(reg_req, OFS_TEMP_SENSOR_CTRL) |=> sensor_ctrl.enable == $past(reg_req.wdata[0]))
    else $error("sensor enable not taken from bit 0");

  chk_temp_readback: assert property (
    s_rd(OFS_TEMPERATURE_HIGH) ##0 !(temp_valid && sens_q.enable) |=> rd_data == temp_q[15:8])
    else $error("temperature high byte readback wrong");

  chk_part_id_read: assert property (
    s_rd(OFS_PART_IDENTIFIER) |=> rd_data == PART_ID_VALUE)
    else $error("identification register not fixed");

  chk_irq_test_mode: assert property (
    wr_hit(reg_req, OFS_IRQ_CONFIGURATION) && reg_req.wdata == IRQ_MODE_RECOMMENDED
    |=> !irq_test_mode && irq_mode_select == IRQ_MODE_RECOMMENDED)
    else $error("interrupt mode select wrong");

  chk_unimpl_zero: assert property (
    s_rd(OFS_Q_FULLSCALE_HIGH) or s_rd(OFS_TEMP_SENSOR_CTRL)
    |=> (rd_data[7] == 1'b0) && ($past(reg_req.addr) != OFS_Q_FULLSCALE_HIGH || rd_data[7:2] == 6'h00))
    else $error("unimplemented bits read nonzero");

  // ----------------------------------------------------------------
  // Full-scale code checks
  // ----------------------------------------------------------------
  chk_fs_low_hold: assert property (
    !wr_hit(reg_req, OFS_Q_FULLSCALE_LOW)
    |=> $stable(q_fullscale_code[7:0]))
    else $error("full-scale low byte changed without a write");

  chk_fs_high_hold: assert property (
    !wr_hit(reg_req, OFS_Q_FULLSCALE_HIGH)
    |=> $stable(q_fullscale_code[9:8]))
    else $error("full-scale high bits changed without a write");

  chk_fs_low_read: assert property (
    s_rd(OFS_Q_FULLSCALE_LOW)
    |=> rd_data == $past(q_fullscale_code[7:0]))
    else $error("full-scale low byte reads back wrong");

  chk_fs_high_read: assert property (
    s_rd(OFS_Q_FULLSCALE_HIGH)
    |=> rd_data[1:0] == $past(q_fullscale_code[9:8]))
    else $error("full-scale high bits read back wrong");

  chk_fs_reset_parts: assert property (
    $rose(rst_b)
    |-> q_fullscale_code[7:0] == RST_Q_FULLSCALE_LOW && q_fullscale_code[9:8] == RST_Q_FULLSCALE_HIGH)
    else $error("full-scale parts not at reset values");

  // ----------------------------------------------------------------
  // Sensor control checks
  // ----------------------------------------------------------------
  chk_sensor_hold: assert property (
    !wr_hit(reg_req, OFS_TEMP_SENSOR_CTRL)
    |=> $stable(sensor_ctrl))
    else $error("sensor control changed without a write");

  chk_span_reset: assert property (
    $rose(rst_b)
    |-> sensor_ctrl.span_current == RST_SPAN_CURRENT)
    else $error("span current not at reset value");

  chk_ref_reset: assert property (
    $rose(rst_b)
    |-> sensor_ctrl.ref_current == RST_REF_CURRENT)
    else $error("reference current not at reset value");

  chk_enable_reset: assert property (
    $rose(rst_b)
    |-> sensor_ctrl.enable == RST_SENSOR_ENABLE)
    else $error("sensor enable not cleared by reset");

  chk_sensor_read: assert property (
    s_rd(OFS_TEMP_SENSOR_CTRL)
    |=> rd_data[6:0] == $past(sensor_ctrl))
    else $error("sensor control reads back wrong");

  // ----------------------------------------------------------------
  // Temperature checks
  // ----------------------------------------------------------------
  chk_temp_capture: assert property (
    s_temp_take
    |=> temp_q == $past(temp_value))
    else $error("temperature sample not captured");

  chk_temp_gated: assert property (
    s_temp_quiet
    |=> $stable(temp_q))
    else $error("temperature changed while sensor idle");

  chk_temp_low_read: assert property (
    s_rd(OFS_TEMPERATURE_LOW) ##0 s_temp_quiet
    |=> rd_data == temp_q[7:0])
    else $error("temperature low byte readback wrong");

  chk_temp_reset: assert property (
    $rose(rst_b)
    |-> temp_q == 16'h0000)
    else $error("temperature not zero after reset");

  // ----------------------------------------------------------------
  // Identification, interrupt mode, read path and full-scale high write checks
  // ----------------------------------------------------------------
  chk_part_id_stand: assert property (
    s_rd(OFS_PART_IDENTIFIER) ##1 !reg_req.rd
    |=> rd_data == 8'h00)
    else $error("read data did not return to zero");

  chk_rd_idle_zero: assert property (
    !reg_req.rd
    |=> rd_data == 8'h00)
    else $error("read data nonzero without a read");

  chk_irq_store: assert property (
    s_wr(OFS_IRQ_CONFIGURATION)
    |=> irq_mode_select == $past(reg_req.wdata))
    else $error("irq_mode_select not stored");

  chk_irq_hold: assert property (
    !wr_hit(reg_req, OFS_IRQ_CONFIGURATION)
    |=> $stable(irq_mode_select))
    else $error("irq_mode_select changed without a write");

  chk_irq_back_test: assert property (
    s_wr(OFS_IRQ_CONFIGURATION) ##0 (reg_req.wdata == IRQ_MODE_TEST)
    |=> irq_test_mode)
    else $error("test mode not selected by 0x00");

  chk_irq_reset: assert property (
    $rose(rst_b)
    |-> irq_test_mode && irq_mode_select == RST_IRQ_MODE_SELECT)
    else $error("irq_mode_select not in test mode after reset");

  chk_irq_read: assert property (
    s_rd(OFS_IRQ_CONFIGURATION)
    |=> rd_data == $past(irq_mode_select))
    else $error("irq_mode_select reads back wrong");

  // Unmapped offsets must not alias onto a neighbouring register
  chk_unmapped_zero: assert property (
    reg_req.rd && (reg_req.addr < OFS_Q_FULLSCALE_LOW || reg_req.addr > OFS_IRQ_CONFIGURATION)
    |=> rd_data == 8'h00)
    else $error("unmapped offset reads nonzero");

  chk_fs_high_write: assert property (
    s_wr(OFS_Q_FULLSCALE_HIGH)
    |=> q_fullscale_code[9:8] == $past(reg_req.wdata[FS_HIGH_MSB:0]))
    else $error("full-scale high write took wrong bits");

endmodule

// ==== testbench/dac_misc_config_registers_tb_top.sv ====
// Testbench: register bank reset values, access kinds, field decode and temperature capture
`timescale 1ns/10ps

module dac_misc_config_registers_tb_top;
  import misc_cfg_pkg::*;

  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  reg_req_t     reg_req = '0;
  logic [7:0]   rd_data;
  logic         temp_valid = 1'b0;
  logic [15:0]  temp_value = 16'h0000;
  logic [9:0]   q_fullscale_code;
  sensor_ctrl_t sensor_ctrl;
  logic [7:0]   irq_mode_select;
  logic         irq_test_mode;
  logic [2:0]   c;
  int           bad_count = 0;
  int           checked = 0;

  dac_misc_config_registers u_dut (
    .mclk             (mclk),
    .rst_b            (rst_b),
    .reg_req          (reg_req),
    .rd_data          (rd_data),
    .temp_valid       (temp_valid),
    .temp_value       (temp_value),
    .q_fullscale_code (q_fullscale_code),
    .sensor_ctrl      (sensor_ctrl),
    .irq_mode_select  (irq_mode_select),
    .irq_test_mode    (irq_test_mode)
  );

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
    @(negedge mclk);
  endtask

  // Read data is looked at only in the single cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    @(negedge mclk);
    chk({8'h00, rd_data}, {8'h00, e});
  endtask

  task automatic temp_pulse(input logic [15:0] v);
    @(posedge mclk);
    temp_valid <= 1'b1;
    temp_value <= v;
    @(posedge mclk);
    temp_valid <= 1'b0;
    temp_value <= ~v;
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: whole sequence needs well under 300 cycles
  // ----------------------------------------------------------------
  initial begin
    #(25 * 2000);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk({6'h00, q_fullscale_code}, 16'h01f9);
    chk({9'h000, sensor_ctrl}, 16'h0002);
    chk({7'h00, irq_test_mode, irq_mode_select}, 16'h0100);
    rd_chk(OFS_Q_FULLSCALE_LOW, 8'hf9);
    rd_chk(OFS_Q_FULLSCALE_HIGH, 8'h01);
    rd_chk(OFS_TEMP_SENSOR_CTRL, 8'h02);
    rd_chk(OFS_TEMPERATURE_LOW, 8'h00);
    rd_chk(OFS_TEMPERATURE_HIGH, 8'h00);
    rd_chk(OFS_PART_IDENTIFIER, 8'h5c);
    @(negedge mclk);
    chk({8'h00, rd_data}, 16'h0000);
    rd_chk(OFS_IRQ_CONFIGURATION, 8'h00);
    wr_reg(OFS_Q_FULLSCALE_LOW, 8'h5a);
    wr_reg(OFS_Q_FULLSCALE_HIGH, 8'hfe);
    chk({6'h00, q_fullscale_code}, 16'h025a);
    rd_chk(OFS_Q_FULLSCALE_HIGH, 8'h02);
    rd_chk(OFS_Q_FULLSCALE_LOW, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr_reg(OFS_TEMP_SENSOR_CTRL, {1'b1, c, ~c, 1'b1});
      chk({9'h000, sensor_ctrl}, {9'h000, c, ~c, 1'b1});
      rd_chk(OFS_TEMP_SENSOR_CTRL, {1'b0, c, ~c, 1'b1});
    end
    wr_reg(OFS_TEMP_SENSOR_CTRL, 8'h02);
    temp_pulse(16'h1234);
    rd_chk(OFS_TEMPERATURE_LOW, 8'h00);
    wr_reg(OFS_TEMP_SENSOR_CTRL, 8'h03);
    temp_pulse(16'hbeef);
    rd_chk(OFS_TEMPERATURE_LOW, 8'hef);
    rd_chk(OFS_TEMPERATURE_HIGH, 8'hbe);
    wr_reg(OFS_TEMPERATURE_LOW, 8'h11);
    wr_reg(OFS_TEMPERATURE_HIGH, 8'h22);
    wr_reg(OFS_PART_IDENTIFIER, 8'ha5);
    rd_chk(OFS_TEMPERATURE_LOW, 8'hef);
    rd_chk(OFS_TEMPERATURE_HIGH, 8'hbe);
    rd_chk(OFS_PART_IDENTIFIER, 8'h5c);
    wr_reg(IRQ_MODE_RECOMMENDED, 8'h00);
    wr_reg(OFS_IRQ_CONFIGURATION, IRQ_MODE_RECOMMENDED);
    chk({7'h00, irq_test_mode, irq_mode_select}, 16'h0001);
    rd_chk(OFS_IRQ_CONFIGURATION, 8'h01);
    wr_reg(OFS_IRQ_CONFIGURATION, IRQ_MODE_TEST);
    chk({7'h00, irq_test_mode, irq_mode_select}, 16'h0100);
    wr_reg(8'h30, 8'hff);
    rd_chk(8'h30, 8'h00);
    chk({6'h00, q_fullscale_code}, 16'h025a);
    complete_run();
  end
endmodule
